/* ffm_defs.svh */
// Constants for the flow forward meter
`ifndef FFM_DEFS_SVH
`define FFM_DEFS_SVH
`define FFM_PORT_PERENTRY 16'hFFFF
`define FFM_QCNT_PERENTRY 28'hFFFFFFF
`define FFM_REFILL_NS 1000
`define FFM_CLK_NS 100
`define FFM_REFILL_CYC ((`FFM_REFILL_NS + `FFM_CLK_NS - 1) / `FFM_CLK_NS)
`define FFM_AGE_TICK_CYC 10000000
`define FFM_BKT_RST 32'h00000000
`endif

/* ffm_pkg.sv */
// Types for the flow forward meter
package ffm_pkg;
  typedef enum logic [2:0] {FFM_FWD_HOST, FFM_FWD_WIRE, FFM_FWD_PIPE, FFM_FWD_DROP,
    FFM_FWD_DEFER} ffm_fwd_e;
  typedef enum logic [1:0] {FFM_GREEN, FFM_YELLOW, FFM_RED} ffm_color_e;
  typedef enum logic [1:0] {FFM_SR, FFM_TR, FFM_TR_EX} ffm_mode_e;
  typedef struct packed
  {
    ffm_fwd_e fwd;
    logic [15:0] port_selector;
    logic [27:0] queue_count_field;
    logic [15:0] queue_mask;
    logic [15:0] next_pipe;
  } ffm_target_s;
  typedef struct packed
  {
    ffm_fwd_e fwd;
    logic [15:0] dest;
    logic [15:0] queue_mask;
    ffm_color_e color;
    logic [15:0] len;
  } ffm_result_s;
endpackage

/* ffm_buf2.sv */
// Two-entry skid buffer
module ffm_buf2 import ffm_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] d0_reg, d0_next, d1_reg, d1_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;
  initial
  begin
    if (W < 1) $error("bad width");
  end
  assign in_ready_o = cnt_reg != 2'h2;
  assign out_valid_o = cnt_reg != 2'h0;
  assign out_data_o = d0_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb
  begin
    d0_next = d0_reg;
    d1_next = d1_reg;
    cnt_next = cnt_reg;
    if (pop)
    begin
      d0_next = d1_reg;
    end
    if (push)
    begin
      if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop))
        d0_next = in_data_i;
      else
        d1_next = in_data_i;
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      d0_reg <= '0;
      d1_reg <= '0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      d0_reg <= d0_next;
      d1_reg <= d1_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* ffm_bucket.sv */
// Token bucket with periodic refill and overflow output
`include "ffm_defs.svh"
module ffm_bucket import ffm_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic [31:0] rate_i,
  input wire logic [31:0] burst_i,
  input wire logic [31:0] spill_in_i,
  input wire logic debit_i,
  input wire logic [31:0] amount_i,
  output logic [31:0] level_o,
  output logic [31:0] spill_o
);
  logic [31:0] lvl_reg, lvl_next;
  logic [32:0] sum;
  always_comb
  begin
    lvl_next = lvl_reg;
    spill_o = 32'h0;
    sum = {1'b0, lvl_reg};
    if (debit_i && lvl_reg >= amount_i)
      sum = {1'b0, lvl_reg - amount_i};
    if (tick_i)
      sum = sum + {1'b0, rate_i} + {1'b0, spill_in_i};
    if (sum > {1'b0, burst_i})
    begin
      spill_o = tick_i ? 32'(sum - {1'b0, burst_i}) : 32'h0;
      lvl_next = burst_i;
    end
    else
      lvl_next = sum[31:0];
  end
  assign level_o = lvl_reg;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lvl_reg <= `FFM_BKT_RST;
    else
      lvl_reg <= lvl_next;
  end
endmodule

/* ffm_top.sv */
// Forward resolution, meter and entry aging
// Overview of operation
// - Metered entry without own target uses the pipe-level target.
// - Entry with idle timeout ages out after timeout without matches.
// - Forward is final step; exactly one of host, wire, pipe, drop.
// - Non-deferred pipe target wins; else entry target, never deferred itself; an entry DEFER is output as drop.
// - Queue spread takes any queue subset; one queue steers all there.
// - Queue count all-ones means entry supplies queue-spread data.
// - Port selector FFFF means entry supplies destination port.
// - Port-forwarded packets stay in hardware, never reach software.
// - Shared resources numbered from zero per resource type.
// - Meter colours packets green, yellow or red for next pipe.
// - Single rate: committed spills into excess; green, yellow, red.
// - Single rate: pre-yellow packet draws only from excess bucket.
// - Two rate: peak bucket separate, debited with committed; red above peak.
// - Two rate: pre-yellow packet draws from peak bucket.
// - Excess-rate mode: second bucket takes excess rate plus overflow.
`include "ffm_defs.svh"
module ffm_top import ffm_pkg::*; #(
  parameter int ENTRIES = 8,
  parameter int AGE_TICK_CYC = `FFM_AGE_TICK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire ffm_target_s pipe_tgt_i,
  input wire logic meter_en_i,
  input wire ffm_mode_e meter_mode_i,
  input wire logic [31:0] cir_i,
  input wire logic [31:0] cbs_i,
  input wire logic [31:0] second_rate_i,
  input wire logic [31:0] second_burst_i,
  input wire logic entry_wr_i,
  input wire logic [$clog2(ENTRIES)-1:0] entry_idx_i,
  input wire ffm_target_s entry_tgt_i,
  input wire logic entry_has_tgt_i,
  input wire logic [15:0] entry_age_i,
  input wire logic pkt_valid_i,
  output logic pkt_ready_o,
  input wire logic [$clog2(ENTRIES)-1:0] pkt_idx_i,
  input wire logic [15:0] pkt_len_i,
  input wire logic pkt_pre_yellow_i,
  output logic res_valid_o,
  input wire logic res_ready_i,
  output ffm_result_s res_o,
  output logic [ENTRIES-1:0] entry_live_o,
  output logic aged_o,
  output logic [$clog2(ENTRIES)-1:0] aged_idx_o
);
  localparam int IW = $clog2(ENTRIES);
  localparam int RW = $bits(ffm_result_s);
  initial
  begin
    if (ENTRIES < 2 || AGE_TICK_CYC < 1) $error("bad parameters");
  end
  ffm_target_s etgt_reg [ENTRIES], etgt_next [ENTRIES];
  logic [ENTRIES-1:0] ehas_reg, ehas_next, live_reg, live_next, hit;
  logic [15:0] eage_reg [ENTRIES], eage_next [ENTRIES];
  logic [15:0] idle_reg [ENTRIES], idle_next [ENTRIES];
  logic [IW-1:0] ref_cnt_reg, ref_cnt_next;
  logic [31:0] age_cnt_reg, age_cnt_next;
  logic ref_tick, age_tick;
  logic take;
  ffm_target_s sel;
  ffm_result_s res_d;
  logic [31:0] c_lvl, s_lvl, c_spill, s_spill, amt;
  logic c_deb, s_deb;
  ffm_color_e color;
  logic [15:0] rcnt_reg, rcnt_next;
  logic aged_reg, aged_next;
  logic [IW-1:0] aged_idx_reg, aged_idx_next;
  assign take = pkt_valid_i && pkt_ready_o;
  assign amt = {16'h0, pkt_len_i};
  assign ref_tick = rcnt_reg == 16'(`FFM_REFILL_CYC - 1);
  assign age_tick = age_cnt_reg == 32'(AGE_TICK_CYC - 1);
  // Per-entry state, entries numbered from zero
  generate
    for (genvar g = 0; g < ENTRIES; g++)
    begin : g_ent
      assign hit[g] = take && pkt_idx_i == IW'(g);
      always_comb
      begin
        etgt_next[g] = etgt_reg[g];
        ehas_next[g] = ehas_reg[g];
        eage_next[g] = eage_reg[g];
        live_next[g] = live_reg[g];
        idle_next[g] = idle_reg[g];
        if (hit[g])
          idle_next[g] = 16'h0;
        else if (age_tick && live_reg[g] && eage_reg[g] != 16'h0)
        begin
          idle_next[g] = idle_reg[g] + 16'h1;
          if (idle_reg[g] + 16'h1 >= eage_reg[g])
            live_next[g] = 1'b0;
        end
        if (entry_wr_i && entry_idx_i == IW'(g))
        begin
          etgt_next[g] = entry_tgt_i;
          ehas_next[g] = entry_has_tgt_i;
          eage_next[g] = entry_age_i;
          live_next[g] = 1'b1;
          idle_next[g] = 16'h0;
        end
      end
      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          etgt_reg[g] <= '0;
          ehas_reg[g] <= 1'b0;
          eage_reg[g] <= 16'h0;
          live_reg[g] <= 1'b0;
          idle_reg[g] <= 16'h0;
        end
        else
        begin
          etgt_reg[g] <= etgt_next[g];
          ehas_reg[g] <= ehas_next[g];
          eage_reg[g] <= eage_next[g];
          live_reg[g] <= live_next[g];
          idle_reg[g] <= idle_next[g];
        end
      end
    end
  endgenerate
  assign entry_live_o = live_reg;
  // Forward selection
  always_comb
  begin
    sel = pipe_tgt_i;
    if (pipe_tgt_i.fwd == FFM_FWD_DEFER && ehas_reg[pkt_idx_i])
      sel = etgt_reg[pkt_idx_i];
    else if (meter_en_i && !ehas_reg[pkt_idx_i])
      sel = pipe_tgt_i;
    if (pipe_tgt_i.port_selector == `FFM_PORT_PERENTRY)
      sel.port_selector = etgt_reg[pkt_idx_i].port_selector;
    if (pipe_tgt_i.queue_count_field == `FFM_QCNT_PERENTRY)
    begin
      sel.queue_count_field = etgt_reg[pkt_idx_i].queue_count_field;
      sel.queue_mask = etgt_reg[pkt_idx_i].queue_mask;
    end
  end
  // Meter colouring
  always_comb
  begin
    c_deb = 1'b0;
    s_deb = 1'b0;
    color = FFM_GREEN;
    if (meter_mode_i == FFM_TR)
    begin
      if (s_lvl < amt)
        color = FFM_RED;
      else if (pkt_pre_yellow_i)
      begin
        color = FFM_YELLOW;
        s_deb = 1'b1;
      end
      else if (c_lvl >= amt)
      begin
        c_deb = 1'b1;
        s_deb = 1'b1;
      end
      else
      begin
        color = FFM_YELLOW;
        s_deb = 1'b1;
      end
    end
    else
    begin
      if (!pkt_pre_yellow_i && c_lvl >= amt)
        c_deb = 1'b1;
      else if (s_lvl >= amt)
      begin
        color = FFM_YELLOW;
        s_deb = 1'b1;
      end
      else
        color = FFM_RED;
    end
    if (!(take && meter_en_i))
    begin
      c_deb = 1'b0;
      s_deb = 1'b0;
    end
  end
  ffm_bucket u_commit (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(ref_tick),
    .rate_i(cir_i),
    .burst_i(cbs_i),
    .spill_in_i(32'h0),
    .debit_i(c_deb),
    .amount_i(amt),
    .level_o(c_lvl),
    .spill_o(c_spill)
  );
  // Second bucket: excess in single-rate and excess-rate, peak in two-rate
  assign s_spill = (meter_mode_i == FFM_TR) ? 32'h0 : c_spill;
  ffm_bucket u_second (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_i(ref_tick),
    .rate_i(meter_mode_i == FFM_SR ? 32'h0 : second_rate_i),
    .burst_i(second_burst_i),
    .spill_in_i(s_spill),
    .debit_i(s_deb),
    .amount_i(amt),
    .level_o(s_lvl),
    .spill_o()
  );
  // Result build
  always_comb
  begin
    res_d = '0;
    res_d.fwd = sel.fwd == FFM_FWD_DEFER ? FFM_FWD_DROP : sel.fwd;
    res_d.len = pkt_len_i;
    res_d.color = meter_en_i ? color : FFM_GREEN;
    case (res_d.fwd)
      FFM_FWD_WIRE: res_d.dest = sel.port_selector;
      FFM_FWD_PIPE: res_d.dest = sel.next_pipe;
      FFM_FWD_HOST: res_d.queue_mask = sel.queue_mask;
      default: res_d.dest = 16'h0;
    endcase
  end
  ffm_buf2 #(.W(RW)) u_buf (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(pkt_valid_i),
    .in_ready_o(pkt_ready_o),
    .in_data_i(res_d),
    .out_valid_o(res_valid_o),
    .out_ready_i(res_ready_i),
    .out_data_o(res_o)
  );
  // Timers and aging report
  always_comb
  begin
    rcnt_next = ref_tick ? 16'h0 : rcnt_reg + 16'h1;
    age_cnt_next = age_tick ? 32'h0 : age_cnt_reg + 32'h1;
    ref_cnt_next = ref_cnt_reg;
    aged_next = 1'b0;
    aged_idx_next = aged_idx_reg;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (live_reg[i] && !live_next[i] && !aged_next)
      begin
        aged_next = 1'b1;
        aged_idx_next = IW'(i);
      end
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rcnt_reg <= 16'h0;
      age_cnt_reg <= 32'h0;
      ref_cnt_reg <= '0;
      aged_reg <= 1'b0;
      aged_idx_reg <= '0;
    end
    else
    begin
      rcnt_reg <= rcnt_next;
      age_cnt_reg <= age_cnt_next;
      ref_cnt_reg <= ref_cnt_next;
      aged_reg <= aged_next;
      aged_idx_reg <= aged_idx_next;
    end
  end
  assign aged_o = aged_reg;
  assign aged_idx_o = aged_idx_reg;
endmodule

/* ffm_sink.sv */
// Result receiver model that stalls when commanded
module ffm_sink (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  output logic res_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready only out of reset and not stalled
  assign res_ready_o = rst_n_i && !stall_i;
endmodule

/* ffm_top_asserts.sv */
// Assertions for the flow forward meter top
module ffm_top_chk import ffm_pkg::*; #(
  parameter int ENTRIES = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic entry_wr_i,
  input wire logic [$clog2(ENTRIES)-1:0] entry_idx_i,
  input wire logic pkt_valid_i,
  input wire logic pkt_ready_o,
  input wire logic res_valid_o,
  input wire logic res_ready_i,
  input wire ffm_result_s res_o,
  input wire logic [ENTRIES-1:0] entry_live_o,
  input wire logic aged_o,
  input wire logic [$clog2(ENTRIES)-1:0] aged_idx_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_HOLD: assert property (
    res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_o))
    else $error("result changed while stalled");
  AST_ONE_FWD: assert property (
    res_valid_o |-> res_o.fwd inside {FFM_FWD_HOST, FFM_FWD_WIRE, FFM_FWD_PIPE, FFM_FWD_DROP})
    else $error("result forward not final");
  AST_ANSWER: assert property (
    pkt_valid_i && pkt_ready_o && !res_valid_o |=> res_valid_o)
    else $error("no result one cycle after take");
  AST_REFUSE: assert property (
    !pkt_ready_o |-> res_valid_o)
    else $error("packet refused with empty buffer");
  AST_AGE_PULSE: assert property (
    aged_o |=> !aged_o)
    else $error("aged pulse too long");
  AST_AGE_KILL: assert property (
    aged_o |-> ##[0:1] !entry_live_o[aged_idx_o])
    else $error("aged entry still live");
  AST_WR_LIVE: assert property (
    entry_wr_i |=> entry_live_o[$past(entry_idx_i)])
    else $error("written entry not live");
  AST_COLOR: assert property (
    res_valid_o |-> res_o.color != 2'h3)
    else $error("bad colour code");
endmodule

bind ffm_top ffm_top_chk #(.ENTRIES(ENTRIES)) ffm_top_chk_inst (.clock_i, .rst_n_i,
  .entry_wr_i, .entry_idx_i, .pkt_valid_i, .pkt_ready_o, .res_valid_o, .res_ready_i,
  .res_o, .entry_live_o, .aged_o, .aged_idx_o);

/* flow_forward_meter_tb.sv */
// Testbench for the flow forward meter
module flow_forward_meter_tb import ffm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_n_i, men, ewr, eht, pv, py, stall, pr, rv, rr, ag;
  ffm_target_s pt, et;
  ffm_mode_e mode;
  logic [31:0] cir, cbs, sr, sb;
  logic [2:0] eidx, pidx, aidx;
  logic [15:0] eage, plen;
  logic [7:0] live;
  ffm_result_s ro, r;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  ffm_mode_e mm [5] = '{FFM_SR, FFM_SR, FFM_SR, FFM_TR, FFM_TR_EX};
  int cirs [5] = '{0, 100, 100, 100, 100};
  int sbs [5] = '{0, 0, 0, 200, 300};
  int srs [5] = '{0, 0, 0, 100, 0};
  int lens [5] = '{10, 50, 10, 10, 250};
  logic pys [5] = '{0, 0, 1, 1, 0};
  ffm_color_e ce [5] = '{FFM_RED, FFM_GREEN, FFM_RED, FFM_YELLOW, FFM_YELLOW};
  ffm_top #(.ENTRIES(8), .AGE_TICK_CYC(10)) ffm_top_inst (.clock_i, .rst_n_i,
    .pipe_tgt_i(pt), .meter_en_i(men), .meter_mode_i(mode), .cir_i(cir), .cbs_i(cbs),
    .second_rate_i(sr), .second_burst_i(sb), .entry_wr_i(ewr), .entry_idx_i(eidx),
    .entry_tgt_i(et), .entry_has_tgt_i(eht), .entry_age_i(eage), .pkt_valid_i(pv),
    .pkt_ready_o(pr), .pkt_idx_i(pidx), .pkt_len_i(plen), .pkt_pre_yellow_i(py),
    .res_valid_o(rv), .res_ready_i(rr), .res_o(ro), .entry_live_o(live),
    .aged_o(ag), .aged_idx_o(aidx));
  ffm_sink ffm_sink_inst (.clock_i, .rst_n_i, .stall_i(stall), .res_ready_o(rr));
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (e !== s)
    begin
      err_count++;
      $display("MISMATCH %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic wr(logic [2:0] i, ffm_target_s t, logic h, logic [15:0] a);
    @(posedge clock_i);
    ewr <= 1'b1;
    eidx <= i;
    et <= t;
    eht <= h;
    eage <= a;
    @(posedge clock_i);
    ewr <= 1'b0;
  endtask
  task automatic send(logic [2:0] i, logic [15:0] l, logic y);
    @(posedge clock_i);
    pv <= 1'b1;
    pidx <= i;
    plen <= l;
    py <= y;
    do @(negedge clock_i); while (pr !== 1'b1);
    @(posedge clock_i);
    pv <= 1'b0;
  endtask
  task automatic get();
    do @(negedge clock_i); while (!(rv === 1'b1 && rr === 1'b1));
    r = ro;
    @(posedge clock_i);
  endtask
  task automatic t_fwd();
    // Pipes carry no mirror, so pipe forward alone applies
    pt <= '{FFM_FWD_WIRE, 16'h0005, 28'h0, 16'h0, 16'h0};
    wr(3'h0, '{FFM_FWD_HOST, 16'h0009, 28'h1, 16'h0001, 16'h0}, 1'b1, 16'h0);
    send(3'h0, 16'h0040, 1'b0);
    get();
    chk("fwd pipe wins", FFM_FWD_WIRE, r.fwd);
    chk("wire dest", 32'h5, r.dest);
    pt <= '{FFM_FWD_DEFER, 16'h0, 28'hFFFFFFF, 16'h0, 16'h0};
    wr(3'h1, '{FFM_FWD_HOST, 16'h0, 28'h1, 16'h0004, 16'h0}, 1'b1, 16'h0);
    send(3'h1, 16'h0040, 1'b0);
    get();
    chk("fwd entry", FFM_FWD_HOST, r.fwd);
    chk("one queue", 32'h4, r.queue_mask);
    wr(3'h2, '{FFM_FWD_DEFER, 16'h0, 28'h0, 16'h0, 16'h0}, 1'b1, 16'h0);
    send(3'h2, 16'h0040, 1'b0);
    get();
    chk("fwd defer drop", FFM_FWD_DROP, r.fwd);
    $display("test fwd done");
  endtask
  task automatic t_port();
    pt <= '{FFM_FWD_WIRE, 16'hFFFF, 28'h0, 16'h0, 16'h0};
    wr(3'h1, '{FFM_FWD_WIRE, 16'h0011, 28'h0, 16'h0, 16'h0}, 1'b1, 16'h0);
    wr(3'h2, '{FFM_FWD_WIRE, 16'h0022, 28'h0, 16'h0, 16'h0}, 1'b1, 16'h0);
    stall <= 1'b1;
    send(3'h1, 16'h0010, 1'b0);
    send(3'h2, 16'h0010, 1'b0);
    @(negedge clock_i);
    chk("full refuse", 32'h0, pr);
    @(posedge clock_i);
    stall <= 1'b0;
    get();
    chk("port first", 32'h11, r.dest);
    get();
    chk("port second", 32'h22, r.dest);
    $display("test port done");
  endtask
  task automatic t_age();
    wr(3'h3, '{FFM_FWD_WIRE, 16'h0001, 28'h0, 16'h0, 16'h0}, 1'b1, 16'h0002);
    @(negedge clock_i);
    chk("live after write", 32'h1, live[3]);
    repeat (60) @(posedge clock_i);
    @(negedge clock_i);
    chk("aged out", 32'h0, live[3]);
    $display("test age done");
  endtask
  task automatic t_meter();
    // Pipe target defined with the meter, peak never below committed
    pt <= '{FFM_FWD_WIRE, 16'h0005, 28'h0, 16'h0, 16'h0};
    wr(3'h5, '{FFM_FWD_HOST, 16'h0, 28'h0, 16'h0, 16'h0}, 1'b0, 16'h0);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clock_i);
      men <= 1'b1;
      mode <= mm[k];
      cir <= cirs[k];
      cbs <= cirs[k] * 2;
      sr <= srs[k];
      sb <= sbs[k];
      repeat (60) @(posedge clock_i);
      send(3'h5, lens[k][15:0], pys[k]);
      get();
      chk("colour", ce[k], r.color);
      chk("policer fwd", FFM_FWD_WIRE, r.fwd);
    end
    $display("test meter done");
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    {men, ewr, eht, pv, py, stall} = '0;
    pt = '0;
    et = '0;
    mode = FFM_SR;
    {cir, cbs, sr, sb} = '0;
    {eidx, pidx, eage, plen} = '0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_fwd();
    t_port();
    t_age();
    t_meter();
    tally_and_finish();
  end
endmodule
